// ==== hw/rldt_defs.vh ====
`ifndef RLDT_DEFS_VH
`define RLDT_DEFS_VH

// ----------------------------------------
// Clock selection codes
// ----------------------------------------
`define RLDT_CSEL_INT0     2'h0
`define RLDT_CSEL_INT1     2'h1
`define RLDT_CSEL_INT2     2'h2
`define RLDT_CSEL_EVENT    2'h3

// ----------------------------------------
// Prescaler divide ratios (cycles per tick)
// ----------------------------------------
`define RLDT_DIV0          8'h02
`define RLDT_DIV1          8'h08
`define RLDT_DIV2          8'h20

// ----------------------------------------
// Trigger source selection codes
// ----------------------------------------
`define RLDT_TRG_SOFT      1'b0
`define RLDT_TRG_EXT       1'b1

// ----------------------------------------
// Interrupt identity of the second channel
// ----------------------------------------
`define RLDT_CH1_IRQ_NUM   8'h24
`define RLDT_CH1_VEC_ADDR  24'hFFFF6C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RLDT_CNT_RST       16'h0000

`endif

// ==== hw/rldt_timer.v ====
`include "rldt_defs.vh"

module rldt_timer #(
	parameter N_CH   = 2,
	parameter CNT_W  = 16
) (
	// Clock and reset
	input  wire                    clock,
	input  wire                    arst_n,
	// Per-channel configuration, bit/field per channel
	input  wire [N_CH-1:0]         cnt_enable,
	input  wire [N_CH-1:0]         clk_sel_hi,
	input  wire [N_CH-1:0]         clk_sel_lo,
	input  wire [N_CH-1:0]         trig_sel_ext,
	input  wire [N_CH-1:0]         reload_mode,
	input  wire [N_CH-1:0]         irq_enable,
	input  wire [N_CH-1:0]         io_service_en,
	input  wire [N_CH-1:0]         irq_clear,
	input  wire [N_CH-1:0]         soft_trig,
	input  wire [N_CH*CNT_W-1:0]   reload_value,
	// External pins
	input  wire [N_CH-1:0]         ext_trig_in,
	input  wire [N_CH-1:0]         ext_event_in,
	// Status and requests
	output wire [N_CH*CNT_W-1:0]   down_count_value,
	output wire [N_CH-1:0]         running,
	output wire [N_CH-1:0]         underflow_flag,
	output wire [N_CH-1:0]         cpu_irq,
	output wire [N_CH-1:0]         io_service_req,
	output wire [N_CH-1:0]         uf_pulse,
	output reg  [7:0]              ch1_irq_num,
	output reg  [23:0]             ch1_vec_addr
);

	// ----------------------------------------
	// Shared prescaler
	// ----------------------------------------
	// One free counter feeds all three rates so channels stay phase aligned
	reg  [7:0] pre_ff;
	wire [7:0] nxt_pre;
	reg  [2:0] tick_ff;
	wire [2:0] nxt_tick;

	assign nxt_pre  = (pre_ff == (`RLDT_DIV2 - 8'h01)) ? 8'h00 : pre_ff + 8'h01;
	assign nxt_tick[0] = (pre_ff[0:0] == 1'b1);
	assign nxt_tick[1] = (pre_ff[2:0] == 3'h7);
	assign nxt_tick[2] = (pre_ff[4:0] == 5'h1F);

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pre_ff  <= 8'h00;
			tick_ff <= 3'h0;
		end else begin
			pre_ff  <= nxt_pre;
			tick_ff <= nxt_tick;
		end
	end

	// ----------------------------------------
	// Fixed interrupt identity outputs
	// ----------------------------------------
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ch1_irq_num  <= 8'h00;
			ch1_vec_addr <= 24'h000000;
		end else begin
			ch1_irq_num  <= `RLDT_CH1_IRQ_NUM;
			ch1_vec_addr <= `RLDT_CH1_VEC_ADDR;
		end
	end

	// ----------------------------------------
	// Channels
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_CH; g = g + 1) begin : gen_ch
			reg  [CNT_W-1:0] cnt_ff;
			reg  [CNT_W-1:0] nxt_cnt;
			reg              run_ff;
			reg              nxt_run;
			reg              flag_ff;
			reg              nxt_flag;
			reg              uf_ff;
			reg              nxt_uf;
			reg              sw_d_ff;
			reg              ext_d_ff;
			reg              ev_s1_ff;
			reg              ev_s2_ff;
			reg              ev_d_ff;
			wire [1:0]       csel;
			wire             evt_mode;
			wire             sw_edge;
			wire             ext_edge;
			wire             ev_edge;
			wire             start;
			reg              cnt_tick;

			assign csel     = {clk_sel_hi[g], clk_sel_lo[g]};
			assign evt_mode = (csel == `RLDT_CSEL_EVENT);
			assign sw_edge  = soft_trig[g] & ~sw_d_ff;
			assign ext_edge = ext_trig_in[g] & ~ext_d_ff;
			// Event mode accepts only the soft trigger
			assign start    = cnt_enable[g] & (sw_edge |
				(~evt_mode & (trig_sel_ext[g] == `RLDT_TRG_EXT) & ext_edge));
			// Edge taken between second and third stage, never from the first
			assign ev_edge  = ev_s2_ff & ~ev_d_ff;

			always @* begin
				case (csel)
					`RLDT_CSEL_INT0:  cnt_tick = tick_ff[0];
					`RLDT_CSEL_INT1:  cnt_tick = tick_ff[1];
					`RLDT_CSEL_INT2:  cnt_tick = tick_ff[2];
					`RLDT_CSEL_EVENT: cnt_tick = ev_edge;
					default:          cnt_tick = 1'b0;
				endcase
			end

			always @* begin
				nxt_cnt  = cnt_ff;
				nxt_run  = run_ff;
				nxt_uf   = 1'b0;
				nxt_flag = flag_ff & ~irq_clear[g];
				if (!cnt_enable[g]) begin
					nxt_run = 1'b0;
				end else if (start) begin
					nxt_cnt = reload_value[g*CNT_W +: CNT_W];
					nxt_run = 1'b1;
				end else if (run_ff && cnt_tick) begin
					if (cnt_ff == {CNT_W{1'b0}}) begin
						nxt_uf   = 1'b1;
						nxt_flag = 1'b1;
						if (reload_mode[g]) begin
							nxt_cnt = reload_value[g*CNT_W +: CNT_W];
						end else begin
							nxt_cnt = {CNT_W{1'b1}};
							nxt_run = 1'b0;
						end
					end else begin
						nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end

			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					cnt_ff   <= `RLDT_CNT_RST;
					run_ff   <= 1'b0;
					flag_ff  <= 1'b0;
					uf_ff    <= 1'b0;
					sw_d_ff  <= 1'b0;
					ext_d_ff <= 1'b0;
					ev_s1_ff <= 1'b0;
					ev_s2_ff <= 1'b0;
					ev_d_ff  <= 1'b0;
				end else begin
					cnt_ff   <= nxt_cnt;
					run_ff   <= nxt_run;
					flag_ff  <= nxt_flag;
					uf_ff    <= nxt_uf;
					sw_d_ff  <= soft_trig[g];
					ext_d_ff <= ext_trig_in[g];
					ev_s1_ff <= ext_event_in[g];
					ev_s2_ff <= ev_s1_ff;
					ev_d_ff  <= ev_s2_ff;
				end
			end

			// Outputs registered once more so the top drives only flops
			reg  [CNT_W-1:0] out_cnt_ff;
			reg              out_run_ff;
			reg              out_flag_ff;
			reg              out_irq_ff;
			reg              out_ios_ff;
			reg              out_ufp_ff;

			always @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					out_cnt_ff  <= `RLDT_CNT_RST;
					out_run_ff  <= 1'b0;
					out_flag_ff <= 1'b0;
					out_irq_ff  <= 1'b0;
					out_ios_ff  <= 1'b0;
					out_ufp_ff  <= 1'b0;
				end else begin
					out_cnt_ff  <= cnt_ff;
					out_run_ff  <= run_ff;
					out_flag_ff <= flag_ff;
					out_ufp_ff  <= uf_ff;
					// Service request steals the CPU interrupt while enabled
					out_irq_ff  <= flag_ff & irq_enable[g] & ~io_service_en[g];
					out_ios_ff  <= flag_ff & irq_enable[g] & io_service_en[g];
				end
			end

			// One driver per output slice, straight from the flops
			assign down_count_value[g*CNT_W +: CNT_W] = out_cnt_ff;
			assign running[g]                          = out_run_ff;
			assign underflow_flag[g]                   = out_flag_ff;
			assign cpu_irq[g]                          = out_irq_ff;
			assign io_service_req[g]                   = out_ios_ff;
			assign uf_pulse[g]                         = out_ufp_ff;
		end
	endgenerate

endmodule

// ==== verif/rldt_sva.sv ====
`include "rldt_defs.vh"
module rldt_sva #(parameter N_CH = 2, parameter CNT_W = 16) (
	input wire                   clock, arst_n,
	input wire [N_CH-1:0]        cnt_enable, soft_trig, reload_mode, irq_enable, io_service_en,
	input wire [N_CH-1:0]        running, uf_pulse, underflow_flag, cpu_irq, io_service_req,
	input wire [N_CH*CNT_W-1:0]  reload_value, down_count_value,
	input wire [7:0]             ch1_irq_num,
	input wire [23:0]            ch1_vec_addr
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire [15:0] v0 = down_count_value[15:0];
	wire [15:0] r0 = reload_value[15:0];
	property p_start; $rose(soft_trig[0]) && cnt_enable[0] && $stable(r0) |-> ##[2:3] running[0] && v0 == r0; endproperty
	a_start: assert property (p_start) else $error("start did not load");
	property p_dec; running[0] && $past(running[0]) && $changed(v0) |-> v0 == $past(v0) - 16'h1 || v0 == r0; endproperty
	a_dec: assert property (p_dec) else $error("count step wrong");
	property p_oneshot; uf_pulse[0] && !reload_mode[0] |-> ##[0:2] !running[0]; endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot kept running");
	property p_reload; uf_pulse[1] && reload_mode[1] && cnt_enable[1] |-> running[1]; endproperty
	a_reload: assert property (p_reload) else $error("reload stopped");
	property p_hold; (!cnt_enable[0])[*3] |-> $stable(v0); endproperty
	a_hold: assert property (p_hold) else $error("count moved while disabled");
	property p_off; (!cnt_enable[0])[*3] |-> !running[0]; endproperty
	a_off: assert property (p_off) else $error("running while disabled");
	property p_irq; uf_pulse[0] && irq_enable[0] && !io_service_en[0] |-> cpu_irq[0] && underflow_flag[0]; endproperty
	a_irq: assert property (p_irq) else $error("no cpu request");
	property p_ios; uf_pulse[1] && irq_enable[1] && io_service_en[1] |-> io_service_req[1] && !cpu_irq[1]; endproperty
	a_ios: assert property (p_ios) else $error("service routing wrong");
	property p_id; arst_n ##1 arst_n |-> ch1_irq_num == `RLDT_CH1_IRQ_NUM && ch1_vec_addr == `RLDT_CH1_VEC_ADDR; endproperty
	a_id: assert property (p_id) else $error("channel 1 identity wrong");
endmodule
bind rldt_timer rldt_sva #(.N_CH(N_CH), .CNT_W(CNT_W)) i_sva (.*);

// ==== verif/rldt_pins.sv ====
module rldt_pins (
	input  wire        clock,
	output logic [1:0] ext_trig_in,
	output logic [1:0] ext_event_in
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {ext_trig_in, ext_event_in} = 4'h0;
	// Two-cycle high keeps each edge visible through the synchroniser
	task pulse(input int c, input int n, input bit trg);
		repeat (n) begin
			@(posedge clock) #1;
			if (trg)
				ext_trig_in[c] = 1'b1;
			else
				ext_event_in[c] = 1'b1;
			repeat (2) @(posedge clock);
			#1 {ext_trig_in[c], ext_event_in[c]} = 2'h0;
			repeat (2) @(posedge clock);
		end
	endtask
endmodule

// ==== verif/tb_top.sv ====
`include "rldt_defs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 0, arst_n = 0;
	logic [1:0]  en = 0, hi = 0, lo = 0, tx = 0, rl = 0, ie = 0, io = 0, clr = 0, st = 0;
	logic [31:0] rv = 0;
	wire  [1:0]  etr, eev, run, uf, ufp, irq, ios;
	wire  [31:0] dcv;
	wire  [7:0]  id_num;
	wire  [23:0] id_vec;
	int          miscompares = 0, comparisons = 0, cyc = 0, n;
	int          dv[3] = '{`RLDT_DIV0, `RLDT_DIV1, `RLDT_DIV2};
	rldt_pins i_pins (.clock, .ext_trig_in(etr), .ext_event_in(eev));
	rldt_timer i_dut (.clock, .arst_n, .cnt_enable(en), .clk_sel_hi(hi), .clk_sel_lo(lo),
		.trig_sel_ext(tx), .reload_mode(rl), .irq_enable(ie), .io_service_en(io),
		.irq_clear(clr), .soft_trig(st), .reload_value(rv), .ext_trig_in(etr),
		.ext_event_in(eev), .down_count_value(dcv), .running(run), .underflow_flag(uf),
		.cpu_irq(irq), .io_service_req(ios), .uf_pulse(ufp), .ch1_irq_num(id_num),
		.ch1_vec_addr(id_vec));
	initial forever #5 clock = ~clock;
	always @(posedge clock) if (++cyc == 5000) begin
		miscompares++;
		print_verdict();
	end
	task print_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task step(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task trig(input int c);
		st[c] = 1'b1;
		step(1);
		st[c] = 1'b0;
		step(1);
	endtask
	// Counts cycles up to the next underflow pulse, then moves past it
	task uf_wait(input int c, output int k);
		k = 0;
		while (ufp[c] !== 1'b1 && k < 2000) begin
			step(1);
			k++;
		end
		step(1);
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		step(8);
		arst_n = 1;
		en = 2'h3; rl = 2'h3; ie = 2'h3; rv = {16'h0004, 16'h0002};
		step(1);
		chk({id_num, id_vec}, {`RLDT_CH1_IRQ_NUM, `RLDT_CH1_VEC_ADDR});
		foreach (dv[i]) begin
			{hi[0], lo[0]} = 2'(i);
			trig(0);
			uf_wait(0, n);
			uf_wait(0, n);
			chk(n, 3 * dv[i] - 1);
			chk(irq[0], 1);
		end
		$display("intervals done");
		rl[0] = 0;
		uf_wait(0, n);
		step(2);
		chk(run[0], 0);
		chk(dcv[15:0], 16'hFFFF);
		clr[0] = 1;
		step(1);
		clr[0] = 0;
		step(2);
		chk(uf[0], 0);
		en[0] = 0;
		trig(0);
		step(3);
		chk(run[0], 0);
		chk(dcv[15:0], 16'hFFFF);
		en[0] = 1;
		$display("one-shot and disable done");
		tx[1] = 1; io[1] = 1;
		i_pins.pulse(1, 1, 1);
		uf_wait(1, n);
		uf_wait(1, n);
		chk(n, 5 * `RLDT_DIV0 - 1);
		chk({run[1], ios[1], irq[1]}, 3'h6);
		$display("external start done");
		{hi[0], lo[0]} = `RLDT_CSEL_EVENT; tx[0] = 1;
		i_pins.pulse(0, 1, 1);
		step(4);
		chk(run[0], 0);
		trig(0);
		i_pins.pulse(0, 2, 0);
		step(4);
		chk({uf[0], dcv[15:0]}, 17'h0);
		i_pins.pulse(0, 1, 0);
		step(5);
		chk({uf[0], run[0]}, 2'h2);
		$display("event count done");
		print_verdict();
	end
endmodule
